// [core/rsw_pkg.sv]
// Package: register map, field layout, modes and counts of the reference switchover block
package rsw_pkg;

    // ****************************************
    // Register map (byte addresses)
    // ****************************************
    localparam logic [7:0] RSW_CTRL_OFFSET = 8'h00;
    localparam logic [7:0] RSW_STATUS_OFFSET = 8'h04;
    localparam logic [7:0] RSW_SWCOUNT_OFFSET = 8'h08;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int RSW_CTRL_MODE_LSB = 0;
    localparam int RSW_STAT_A_LOST_BIT = 0;
    localparam int RSW_STAT_B_LOST_BIT = 1;
    localparam int RSW_STAT_SEL_BIT = 2;
    localparam int RSW_STAT_BUSY_BIT = 3;
    localparam int RSW_STAT_REQ_BIT = 4;
    localparam int RSW_STAT_GATE_BIT = 5;

    // ****************************************
    // Modes and states
    // ****************************************
    typedef enum logic [1:0] {
        RSW_MODE_MANUAL = 2'b00,
        RSW_MODE_AUTO = 2'b01,
        RSW_MODE_AUTO_OVR = 2'b10
    } rsw_mode_t;

    typedef enum logic [1:0] {
        RSW_ST_IDLE = 2'b00,
        RSW_ST_WAIT_OLD = 2'b01,
        RSW_ST_WAIT_NEW = 2'b11
    } rsw_state_t;

    // ****************************************
    // Reset values and counts
    // ****************************************
    localparam logic [1:0] RSW_CTRL_MODE_RESET = 2'b00;
    localparam logic RSW_SEL_RESET = 1'b0;
    localparam logic [15:0] RSW_SWCOUNT_RESET = 16'h0000;
    localparam logic [31:0] RSW_PRDATA_RESET = 32'h0000_0000;
    // Reference edges the request must stay high for, per reference
    localparam int RSW_REQ_MIN_CYCLES = 3;
    // Silence longer than this many own periods means the input is lost
    localparam int RSW_LOSS_PERIODS = 2;
    localparam int RSW_CNT_WIDTH = 16;

endpackage

// [core/rsw_clk_if.sv]
// Interface: edge and loss information of one reference input
`timescale 1ns/1ps
`default_nettype none
interface rsw_clk_if;
    logic rise;
    logic fall;
    logic lost;
    modport mon (output rise, output fall, output lost);
    modport core (input rise, input fall, input lost);
endinterface
`default_nettype wire

// [core/rsw_clk_monitor.sv]
// Module: edge detector and loss-of-clock sense for one reference input
`timescale 1ns/1ps
`default_nettype none
module rsw_clk_monitor
    import rsw_pkg::*;
#(
    parameter int CW = RSW_CNT_WIDTH
) (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic refIn,
    rsw_clk_if.mon mon
);

    logic refPrev_reg;
    logic [CW-1:0] sinceRise_reg;
    logic [CW-1:0] period_reg;
    logic seenRise_reg;
    logic periodValid_reg;
    logic lost_reg;
    logic riseNow;
    logic [CW:0] lossLimit;

    assign riseNow = refIn & ~refPrev_reg;
    assign lossLimit = (CW+1)'(RSW_LOSS_PERIODS) * {1'b0, period_reg};
    assign mon.rise = riseNow;
    assign mon.fall = ~refIn & refPrev_reg;
    assign mon.lost = lost_reg;

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            // High: no false rise at release, so no short first period and false loss
            refPrev_reg <= 1'b1;
        end else begin
            refPrev_reg <= refIn;
        end
    end

    // ****************************************
    // Period measurement between rising edges
    // ****************************************
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            sinceRise_reg <= '0;
            period_reg <= '0;
            seenRise_reg <= 1'b0;
            periodValid_reg <= 1'b0;
        end else if (riseNow) begin
            sinceRise_reg <= CW'(1);
            seenRise_reg <= 1'b1;
            if (seenRise_reg) begin
                period_reg <= sinceRise_reg;
                periodValid_reg <= 1'b1;
            end
        end else if (sinceRise_reg != '1) begin
            sinceRise_reg <= sinceRise_reg + CW'(1);
        end
    end

    // Flag rises after about two silent periods, falls on the next rising edge
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            lost_reg <= 1'b0;
        end else if (riseNow) begin
            lost_reg <= 1'b0;
        end else if (periodValid_reg && ({1'b0, sinceRise_reg} > lossLimit)) begin
            lost_reg <= 1'b1;
        end
    end

endmodule
`default_nettype wire

// [core/rsw_req_sync.sv]
// Module: switch request synchroniser, rising-edge arm and high-time qualifier
`timescale 1ns/1ps
`default_nettype none
module rsw_req_sync
    import rsw_pkg::*;
(
    input wire logic clock,
    input wire logic arst_n,
    input wire logic switchRequest,
    rsw_clk_if.core clkA,
    rsw_clk_if.core clkB,
    output logic swapPulse,
    output logic reqLevel
);

    logic sync1_reg;
    logic sync2_reg;
    logic armed_reg;
    logic swap_reg;
    logic [1:0] cntA_reg;
    logic [1:0] cntB_reg;
    logic qualified;

    localparam logic [1:0] MIN_CNT = 2'(RSW_REQ_MIN_CYCLES);

    assign qualified = (cntA_reg >= MIN_CNT) && (cntB_reg >= MIN_CNT);
    assign swapPulse = swap_reg;
    assign reqLevel = sync2_reg;

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
        end else begin
            sync1_reg <= switchRequest; // [RULE_24]
            sync2_reg <= sync1_reg;
        end
    end

    // ****************************************
    // Arm on rising edge, fire once qualified
    // ****************************************
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            armed_reg <= 1'b0;
            swap_reg <= 1'b0;
            cntA_reg <= 2'b00;
            cntB_reg <= 2'b00;
        end else begin
            swap_reg <= 1'b0;
            if (!sync2_reg) begin
                // Falling request only disarms, never swaps back
                armed_reg <= 1'b0; // [RULE_15]
                cntA_reg <= 2'b00;
                cntB_reg <= 2'b00;
            end else if (!armed_reg && !swap_reg && cntA_reg == 2'b00 && cntB_reg == 2'b00) begin
                armed_reg <= 1'b1; // [RULE_15]
            end else if (armed_reg) begin
                // High time counted in edges of both references, so the slower one sets it
                if (clkA.rise && cntA_reg != MIN_CNT) begin
                    cntA_reg <= cntA_reg + 2'b01; // [RULE_02] [RULE_19]
                end
                if (clkB.rise && cntB_reg != MIN_CNT) begin
                    cntB_reg <= cntB_reg + 2'b01; // [RULE_02] [RULE_19]
                end
                if (qualified) begin
                    swap_reg <= 1'b1; // [RULE_02]
                    armed_reg <= 1'b0;
                end
            end
        end
    end

endmodule
`default_nettype wire

// [core/rsw_switchover.sv]
// Module: top of the reference clock switchover block with APB register access
//
// Summary of operation
// (RULE_01) Automatic mode: a stopped selected reference makes the block select the other.
// (RULE_02) Manual mode: request rising and held three reference cycles swaps the reference.
// (RULE_03) Override mode: high request blocks automatic switching while it stays high.
// (RULE_04) Outputs two loss flags and the selected-reference indicator.
// (RULE_05) User connects the backup clock to reference B; A is primary.
// (RULE_06) Automatic mode allows any number of switches back and forth.
// (RULE_07) User keeps both references running, periods within a factor of two.
// (RULE_08) No switchover when the other reference is also stopped.
// (RULE_09) Automatic mode raises an input's loss flag once it stops toggling.
// (RULE_10) Indicator always shows which reference feeds the PLL.
// (RULE_11) About two silent cycles raise the loss flag; mux select moves to backup.
// (RULE_12) Automatic switch completes on a falling edge of the available reference.
// (RULE_13) Gate off on old falling edge, switch mux on new falling edge.
// (RULE_14) Manual switches with both references alive raise no loss flag.
// (RULE_15) Only rising request edges act; each new one starts a new switch.
// (RULE_16) A switch completes only when its target toggles; otherwise it waits.
// (RULE_17) Reference A is selected after reset.
// (RULE_18) User returns the request low before asking for another switch.
// (RULE_19) Request high time counts cycles of the slower reference.
// (RULE_20) User raises the request only while both references run.
// (RULE_21) User should pulse the PLL reset after a switchover.
// (RULE_22) That PLL reset should last at least 10 ns when phase matters.
// (RULE_23) Indicator reads 0 for reference A and 1 for reference B.
// (RULE_24) Request is synchronised before edge detection and high-time counting.
`timescale 1ns/1ps
`default_nettype none
module rsw_switchover
    import rsw_pkg::*;
#(
    parameter int CW = RSW_CNT_WIDTH
) (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic ref_clock_a,
    input wire logic ref_clock_b,
    input wire logic switch_request,
    output logic gated_ref_clock,
    output logic mux_select_drive,
    output logic selected_ref_indicator,
    output logic ref_a_lost,
    output logic ref_b_lost,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);

    // ****************************************
    // Reference monitors and request qualifier
    // ****************************************
    rsw_clk_if clkA ();
    rsw_clk_if clkB ();
    logic swapPulse;
    logic reqLevel;

    rsw_clk_monitor #(.CW(CW)) monA (
        .clock(clock),
        .arst_n(arst_n),
        .refIn(ref_clock_a),
        .mon(clkA)
    );

    rsw_clk_monitor #(.CW(CW)) monB (
        .clock(clock),
        .arst_n(arst_n),
        .refIn(ref_clock_b),
        .mon(clkB)
    );

    rsw_req_sync reqSync (
        .clock(clock),
        .arst_n(arst_n),
        .switchRequest(switch_request),
        .clkA(clkA),
        .clkB(clkB),
        .swapPulse(swapPulse),
        .reqLevel(reqLevel)
    );

    // ****************************************
    // Control state
    // ****************************************
    rsw_state_t state_reg;
    rsw_mode_t mode_reg;
    logic selected_reg;
    logic gateOn_reg;
    logic gatedClk_reg;
    logic lostA_reg;
    logic lostB_reg;
    logic [15:0] swCount_reg;
    logic autoMode;
    logic ovrMode;
    logic curFall;
    logic curLost;
    logic othFall;
    logic othLost;
    logic autoStart;
    logic manStart;
    logic switchDone;

    assign autoMode = (mode_reg == RSW_MODE_AUTO) || (mode_reg == RSW_MODE_AUTO_OVR);
    assign ovrMode = (mode_reg == RSW_MODE_AUTO_OVR);
    assign curFall = selected_reg ? clkB.fall : clkA.fall;
    assign curLost = selected_reg ? clkB.lost : clkA.lost;
    assign othFall = selected_reg ? clkA.fall : clkB.fall;
    assign othLost = selected_reg ? clkA.lost : clkB.lost;
    // Both stopped: stay put, nothing better to switch to
    assign autoStart = autoMode && !(ovrMode && reqLevel) && curLost && !othLost; // [RULE_01] [RULE_03] [RULE_08]
    assign manStart = (mode_reg != RSW_MODE_AUTO) && swapPulse; // [RULE_02] [RULE_15]
    assign switchDone = (state_reg == RSW_ST_WAIT_NEW) && othFall;

    // ****************************************
    // Switchover state machine
    // ****************************************
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            state_reg <= RSW_ST_IDLE;
        end else begin
            unique case (state_reg)
                RSW_ST_IDLE: begin
                    if (manStart || autoStart) begin
                        state_reg <= RSW_ST_WAIT_OLD; // [RULE_06]
                    end
                end
                RSW_ST_WAIT_OLD: begin
                    // A dead old reference may never fall again, so do not wait for it
                    if (curFall || curLost) begin
                        state_reg <= RSW_ST_WAIT_NEW; // [RULE_13]
                    end
                end
                RSW_ST_WAIT_NEW: begin
                    if (othFall) begin
                        state_reg <= RSW_ST_IDLE; // [RULE_12] [RULE_16]
                    end
                end
                default: begin
                    state_reg <= RSW_ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            gateOn_reg <= 1'b1;
        end else if (state_reg == RSW_ST_WAIT_OLD && (curFall || curLost)) begin
            gateOn_reg <= 1'b0; // [RULE_13]
        end else if (switchDone) begin
            gateOn_reg <= 1'b1; // [RULE_13]
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            selected_reg <= RSW_SEL_RESET; // [RULE_17]
        end else if (switchDone) begin
            selected_reg <= ~selected_reg; // [RULE_11] [RULE_23]
        end
    end

    // Registered clock path: gate closes on an old-clock fall or loss, reopens on a new-clock fall
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            gatedClk_reg <= 1'b0;
        end else begin
            gatedClk_reg <= gateOn_reg & (selected_reg ? ref_clock_b : ref_clock_a); // [RULE_13]
        end
    end

    // Loss flags only in the automatic modes; manual swaps never raise them
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            lostA_reg <= 1'b0;
            lostB_reg <= 1'b0;
        end else begin
            lostA_reg <= autoMode & clkA.lost; // [RULE_09] [RULE_11] [RULE_14]
            lostB_reg <= autoMode & clkB.lost; // [RULE_09] [RULE_11] [RULE_14]
        end
    end

    assign gated_ref_clock = gatedClk_reg;
    assign mux_select_drive = selected_reg; // [RULE_11]
    assign selected_ref_indicator = selected_reg; // [RULE_04] [RULE_10] [RULE_23]
    assign ref_a_lost = lostA_reg; // [RULE_04]
    assign ref_b_lost = lostB_reg; // [RULE_04]

    // ****************************************
    // APB slave, one wait state
    // ****************************************
    logic pready_reg;
    logic pslverr_reg;
    logic [31:0] prdata_reg;
    logic [31:0] readValue;
    logic addrHit;
    logic wrCommit;
    logic [7:0] addrLow;

    assign addrLow = paddr[7:0];
    assign addrHit = (paddr[31:8] == 24'h00_0000) && ((addrLow == RSW_CTRL_OFFSET)
        || (addrLow == RSW_STATUS_OFFSET) || (addrLow == RSW_SWCOUNT_OFFSET));
    assign wrCommit = psel && penable && pready_reg && pwrite && addrHit;

    always_comb begin
        readValue = 32'h0000_0000;
        if (addrLow == RSW_CTRL_OFFSET) begin
            readValue[RSW_CTRL_MODE_LSB +: 2] = mode_reg;
        end else if (addrLow == RSW_STATUS_OFFSET) begin
            readValue[RSW_STAT_A_LOST_BIT] = lostA_reg;
            readValue[RSW_STAT_B_LOST_BIT] = lostB_reg;
            readValue[RSW_STAT_SEL_BIT] = selected_reg;
            readValue[RSW_STAT_BUSY_BIT] = (state_reg != RSW_ST_IDLE);
            readValue[RSW_STAT_REQ_BIT] = reqLevel;
            readValue[RSW_STAT_GATE_BIT] = gateOn_reg;
        end else if (addrLow == RSW_SWCOUNT_OFFSET) begin
            readValue[15:0] = swCount_reg;
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= RSW_PRDATA_RESET;
        end else if (psel && penable && !pready_reg) begin
            pready_reg <= 1'b1;
            pslverr_reg <= ~addrHit;
            prdata_reg <= (!pwrite && addrHit) ? readValue : 32'h0000_0000;
        end else begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
        end
    end

    // Illegal mode code falls back to manual
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            mode_reg <= rsw_mode_t'(RSW_CTRL_MODE_RESET);
        end else if (wrCommit && addrLow == RSW_CTRL_OFFSET) begin
            if (pwdata[RSW_CTRL_MODE_LSB +: 2] == 2'b11) begin
                mode_reg <= RSW_MODE_MANUAL;
            end else begin
                mode_reg <= rsw_mode_t'(pwdata[RSW_CTRL_MODE_LSB +: 2]);
            end
        end
    end

    // A completion in the same cycle as a software clear leaves the count at one
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            swCount_reg <= RSW_SWCOUNT_RESET;
        end else if (switchDone) begin
            swCount_reg <= (wrCommit && addrLow == RSW_SWCOUNT_OFFSET) ? 16'h0001 : swCount_reg + 16'h0001;
        end else if (wrCommit && addrLow == RSW_SWCOUNT_OFFSET) begin
            swCount_reg <= RSW_SWCOUNT_RESET;
        end
    end

    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign prdata = prdata_reg;

endmodule
`default_nettype wire

// [dv/rsw_ref_src.sv]
// Model: two reference clock sources that can be stopped
`timescale 1ns/1ps
`default_nettype none
module rsw_ref_src #(
    parameter int HALF_A = 20,
    // Within a factor of two of HALF_A for automatic mode
    parameter int HALF_B = 24
) (
    input wire logic runA,
    input wire logic runB,
    output logic refA,
    output logic refB
);
    // ********
    // Sources: A primary, B backup
    // ********
    // A stopped source sits low, like a dead oscillator
    initial begin
        refA = 1'b0;
        forever begin
            #(HALF_A);
            refA = runA ? ~refA : 1'b0;
        end
    end
    initial begin
        refB = 1'b0;
        forever begin
            #(HALF_B);
            refB = runB ? ~refB : 1'b0;
        end
    end
endmodule
`default_nettype wire

// [dv/rsw_switchover_assertions.sv]
// Checker: selection, gating, loss and APB answer properties
`timescale 1ns/1ps
`default_nettype none
module rsw_switchover_assertions
    import rsw_pkg::*;
#(
    parameter int CW = RSW_CNT_WIDTH
) (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic ref_clock_a,
    input wire logic ref_clock_b,
    input wire logic switch_request,
    input wire logic gated_ref_clock,
    input wire logic selected_ref_indicator,
    input wire logic ref_a_lost,
    input wire logic ref_b_lost,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready
);
    // ********
    // Helper state
    // ********
    logic [1:0] mode_reg;
    logic [7:0] lowCnt_reg, highCnt_reg, quietA_reg;
    logic prevA_reg, selRef, isManual;
    assign selRef = selected_ref_indicator ? ref_clock_b : ref_clock_a;
    // Mode 3 behaves as manual
    assign isManual = (mode_reg[1] == mode_reg[0]);
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            mode_reg <= 2'h0;
        end else if (psel && penable && pready && pwrite
            && paddr == {24'h00_0000, RSW_CTRL_OFFSET}) begin
            mode_reg <= pwdata[1:0];
        end
    end
    // Saturating counts; 255 cycles covers any legal switch latency here
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            lowCnt_reg <= 8'h00;
            highCnt_reg <= 8'h00;
            quietA_reg <= 8'h00;
            prevA_reg <= 1'b0;
        end else begin
            lowCnt_reg <= switch_request ? 8'h00 : lowCnt_reg + {7'h00, ~&lowCnt_reg};
            highCnt_reg <= !switch_request ? 8'h00 : highCnt_reg + {7'h00, ~&highCnt_reg};
            quietA_reg <= (ref_clock_a != prevA_reg) ? 8'h00 : quietA_reg + {7'h00, ~&quietA_reg};
            prevA_reg <= ref_clock_a;
        end
    end
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!arst_n);
    AST_MANUAL_NO_LOST: assert property (isManual [*2] |-> !ref_a_lost && !ref_b_lost)
        else $error("loss flag in manual mode");
    AST_MANUAL_HOLD: assert property (isManual && lowCnt_reg == 8'hFF |-> $stable(selected_ref_indicator))
        else $error("manual switch without request");
    AST_OVR_HOLD: assert property (mode_reg == RSW_MODE_AUTO_OVR && highCnt_reg == 8'hFF |-> $stable(selected_ref_indicator))
        else $error("switch while override request high");
    AST_GATE_OFF: assert property ($changed(selected_ref_indicator) |-> !$past(gated_ref_clock))
        else $error("mux moved with gate open");
    AST_GATE_FOLLOWS: assert property (gated_ref_clock |-> $past(selRef))
        else $error("gated clock not from selected ref");
    AST_LOST_QUIET: assert property ($rose(ref_a_lost) |-> quietA_reg >= 8'h04)
        else $error("ref A flagged while toggling");
    AST_AUTO_SWITCH: assert property (mode_reg == RSW_MODE_AUTO && !selected_ref_indicator && $rose(ref_a_lost) && !ref_b_lost |-> ##[1:200] selected_ref_indicator)
        else $error("no automatic switch to B");
    AST_APB_ONE_WAIT: assert property (psel && penable && !pready |=> pready)
        else $error("APB answer late");
    COV_MANUAL: cover property (isManual && $changed(selected_ref_indicator));
    COV_AUTO: cover property ($rose(ref_a_lost) ##[1:200] selected_ref_indicator);
    COV_APB: cover property (psel && penable && pready && pwrite);
endmodule
bind rsw_switchover rsw_switchover_assertions #(.CW(CW)) u_rsw_switchover_assertions (.*);
`default_nettype wire

// [dv/test_rsw_switchover.sv]
// Testbench: register access, manual, automatic and override switchover runs
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_errors++; \
    $display("BAD %s exp %h got %h", nm, e, g); end end
module test_rsw_switchover
    import rsw_pkg::*;
;
    logic clock, arst_n, runA, runB, refA, refB, switchReq;
    logic psel, penable, pwrite, pready, pslverr, gated, muxSel, ind, aLost, bLost, err;
    logic [31:0] paddr, pwdata, prdata, rd;
    int n_errors, cmp_count;
    rsw_ref_src u_rsw_ref_src (.runA(runA), .runB(runB), .refA(refA), .refB(refB));
    rsw_switchover #(.CW(16)) u_rsw_switchover (
        .clock(clock), .arst_n(arst_n), .ref_clock_a(refA), .ref_clock_b(refB),
        .switch_request(switchReq), .gated_ref_clock(gated), .mux_select_drive(muxSel),
        .selected_ref_indicator(ind), .ref_a_lost(aLost), .ref_b_lost(bLost),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr));
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    // ********
    // Tasks
    // ********
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {24'h00_0000, a};
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        n = 0;
        @(posedge clock);
        while (pready !== 1'b1) begin
            n++;
            @(posedge clock);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        `CHK("apb wait", 1, n)
    endtask
    task automatic wait_ind(input logic e);
        int n;
        n = 0;
        while (ind !== e && n < 400) begin
            n++;
            @(posedge clock);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clock);
        n_errors++;
        wrap_up();
    end
    initial begin
        arst_n = 1'b0;
        runA = 1'b1;
        runB = 1'b1;
        switchReq = 1'b0;
        {psel, penable, pwrite} = 3'h0;
        paddr = 32'h0000_0000;
        pwdata = 32'h0000_0000;
        n_errors = 0;
        cmp_count = 0;
        repeat (4) @(posedge clock);
        arst_n <= 1'b1;
        @(posedge clock);
        `CHK("sel", 1'b0, ind)
        `CHK("lost", 2'b00, {aLost, bLost})
        apb(1'b0, RSW_CTRL_OFFSET, 32'h0000_0000);
        `CHK("ctrl", {30'h0, RSW_CTRL_MODE_RESET}, rd)
        apb(1'b0, RSW_STATUS_OFFSET, 32'h0000_0000);
        `CHK("status", 32'h0000_0000, rd & 32'h0000_0007)
        apb(1'b1, 8'h0C, 32'hFFFF_FFFF);
        `CHK("wr err", 1'b1, err)
        apb(1'b0, 8'h0C, 32'h0000_0000);
        `CHK("rd err", 1'b1, err)
        `CHK("rd data", 32'h0000_0000, rd)
        // Manual swaps in both directions, both sources running
        for (int i = 0; i < 2; i++) begin
            switchReq <= 1'b1;
            wait_ind(i == 0);
            `CHK("man sel", logic'(i == 0), ind)
            `CHK("mux", logic'(i == 0), muxSel)
            `CHK("man lost", 2'b00, {aLost, bLost})
            switchReq <= 1'b0;
            repeat (100) @(posedge clock);
            `CHK("after fall", logic'(i == 0), ind)
        end
        apb(1'b0, RSW_SWCOUNT_OFFSET, 32'h0000_0000);
        `CHK("count", 32'h0000_0002, rd)
        apb(1'b1, RSW_SWCOUNT_OFFSET, 32'h0000_0005);
        apb(1'b0, RSW_SWCOUNT_OFFSET, 32'h0000_0000);
        `CHK("count clr", 32'h0000_0000, rd)
        // Pulse far shorter than three reference periods
        switchReq <= 1'b1;
        repeat (4) @(posedge clock);
        switchReq <= 1'b0;
        repeat (300) @(posedge clock);
        `CHK("short", 1'b0, ind)
        apb(1'b1, RSW_CTRL_OFFSET, 32'h0000_0001);
        repeat (50) @(posedge clock);
        runA <= 1'b0;
        wait_ind(1'b1);
        `CHK("a lost", 1'b1, aLost)
        `CHK("auto b", 1'b1, ind)
        runA <= 1'b1;
        repeat (100) @(posedge clock);
        `CHK("a back", 1'b0, aLost)
        runB <= 1'b0;
        wait_ind(1'b0);
        `CHK("auto a", 1'b0, ind)
        `CHK("b lost", 1'b1, bLost)
        repeat (100) @(posedge clock);
        runA <= 1'b0;
        repeat (150) @(posedge clock);
        `CHK("both dead", 1'b0, ind)
        runB <= 1'b1;
        wait_ind(1'b1);
        `CHK("target up", 1'b1, ind)
        runA <= 1'b1;
        repeat (100) @(posedge clock);
        apb(1'b1, RSW_CTRL_OFFSET, 32'h0000_0002);
        switchReq <= 1'b1;
        wait_ind(1'b0);
        `CHK("ovr sel", 1'b0, ind)
        `CHK("ovr lost", 2'b00, {aLost, bLost})
        runA <= 1'b0;
        repeat (150) @(posedge clock);
        `CHK("ovr a lost", 1'b1, aLost)
        `CHK("ovr held", 1'b0, ind)
        runA <= 1'b1;
        repeat (50) @(posedge clock);
        switchReq <= 1'b0;
        repeat (20) @(posedge clock);
        switchReq <= 1'b1;
        wait_ind(1'b1);
        `CHK("ovr again", 1'b1, ind)
        apb(1'b0, RSW_SWCOUNT_OFFSET, 32'h0000_0000);
        `CHK("count auto", 32'h0000_0005, rd)
        // Reset pulse after the switchovers, three clocks is 12 ns
        switchReq <= 1'b0;
        arst_n <= 1'b0;
        repeat (3) @(posedge clock);
        arst_n <= 1'b1;
        @(posedge clock);
        `CHK("rst sel", 1'b0, ind)
        apb(1'b0, RSW_CTRL_OFFSET, 32'h0000_0000);
        `CHK("rst mode", {30'h0, RSW_CTRL_MODE_RESET}, rd)
        apb(1'b0, RSW_SWCOUNT_OFFSET, 32'h0000_0000);
        `CHK("rst count", 32'h0000_0000, rd)
        wrap_up();
    end
endmodule
`default_nettype wire
